// File: include/dsom_pkg.sv
// constants of the drive status output monitor
package dsom_pkg;
  // register indexes on the plain port
  localparam logic [2:0] A_OVL_LVL1  = 3'h0;
  localparam logic [2:0] A_OVL_LVL2  = 3'h1;
  localparam logic [2:0] A_DEV_LVL   = 3'h2;
  localparam logic [2:0] A_POLARITY  = 3'h3;
  localparam logic [2:0] A_SEL_BASE  = 3'h4;
  localparam logic [2:0] A_STATUS    = 3'h7;
  // reset values, all levels in whole percent
  localparam logic [7:0] OVL_LVL_RST = 8'h64;
  localparam logic [7:0] DEV_LVL_RST = 8'h03;
  localparam logic       POL_NC_RST  = 1'h1;
  // outlet selects: index 0 terminal 11, 1 terminal 12, 2 relay
  localparam logic [2:0][7:0] SEL_RST = {8'h05, 8'h04, 8'h03};
  // option codes
  localparam logic [7:0] OPT_OVL1    = 8'h03;
  localparam logic [7:0] OPT_DEV     = 8'h04;
  localparam logic [7:0] OPT_TRIP    = 8'h05;
  localparam logic [7:0] OPT_OVL2    = 8'h1a;
  // status register bit positions
  localparam int ST_OVL1  = 0;
  localparam int ST_OVL2  = 1;
  localparam int ST_DEV   = 2;
  localparam int ST_TRIP  = 3;
  localparam int ST_COIL  = 4;
  localparam int ST_PWROK = 5;
  // timing
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned ALARM_DLY_MS = 300;
  localparam int unsigned POWERUP_S    = 2;
  localparam int unsigned ALARM_DLY_CYC = ALARM_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned POWERUP_CYC   = POWERUP_S * CLK_HZ;
  localparam int          CNT_W         = 25;
endpackage

// File: src/dsom_cmp.sv
// threshold comparator that holds its state on equality
`timescale 1ns/1ps
module dsom_cmp (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // compared quantity and its threshold
  input  wire logic [7:0] value,
  input  wire logic [7:0] level,
  // result
  output      logic       flag
);
  // equality holds the flag so it cannot chatter at the boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (value > level) begin
      flag <= 1'b1;
    end else if (value < level) begin
      flag <= 1'b0;
    end
  end

  property p_hold;
    @(posedge clk) disable iff (rst)
      (value == level) |=> (flag == $past(flag));
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved at equality");
endmodule

// File: src/dsom_delay.sv
// level delay: output takes the input once it has differed for DELAY cycles
`timescale 1ns/1ps
module dsom_delay #(
  parameter int unsigned DELAY = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and delayed level out
  input  wire logic d,
  output      logic q
);
  localparam logic [dsom_pkg::CNT_W-1:0] LAST = dsom_pkg::CNT_W'(DELAY - 1);

  logic [dsom_pkg::CNT_W-1:0] cnt_ff;

  // a glitch shorter than the delay restarts the count and never reaches q
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      q      <= 1'b0;
    end else if (d == q) begin
      cnt_ff <= '0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      q      <= d;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  property p_lag;
    @(posedge clk) disable iff (rst)
      (q != $past(q)) |-> ($past(cnt_ff) == LAST && $past(d) == q);
  endproperty
  a_lag: assert property (p_lag) else $error("output changed before delay");
endmodule

// File: src/dsom_top.sv
// drive status outputs: overload, pid deviation, trip alarm and relay
`timescale 1ns/1ps
module dsom_top #(
  parameter int unsigned ALARM_DLY_CYC = dsom_pkg::ALARM_DLY_CYC,
  parameter int unsigned POWERUP_CYC   = dsom_pkg::POWERUP_CYC
) (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // register port
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output      logic [7:0] RDATA,
  // measured quantities, percent of rated
  input  wire logic [7:0] OUT_CURRENT,
  input  wire logic [7:0] PID_SETPOINT,
  input  wire logic [7:0] PID_FEEDBACK,
  // internal fault alarm, high while in trip mode
  input  wire logic       TRIP_MODE,
  // open collector terminals 11 and 12
  output      logic [1:0] TERM_O,
  output      logic [1:0] TERM_OE,
  // relay coil drive
  output      logic       RELAY_COIL
);
  logic [7:0]      ovl_lvl_ff [2];
  logic [7:0]      dev_lvl_ff;
  logic            pol_nc_ff;
  logic [7:0]      sel_ff [3];
  logic [1:0]      overload_notice;
  logic            pid_deviation_flag;
  logic            trip_alarm;
  logic            pwr_ok;
  logic [7:0]      dev_mag;
  logic [2:0]      func_now;
  logic [1:0]      term_oe_ff;
  logic [1:0]      term_o_ff;
  logic            coil_ff;
  logic            nxt_coil;
  logic [7:0]      rdata_ff;

  // option code to status function
  function automatic logic pick(input logic [7:0] code, input logic [1:0] ovl,
                                input logic dev, input logic trip);
    logic r;
    r = 1'b0;
    unique case (code)
      dsom_pkg::OPT_OVL1: r = ovl[0];
      dsom_pkg::OPT_OVL2: r = ovl[1];
      dsom_pkg::OPT_DEV:  r = dev;
      dsom_pkg::OPT_TRIP: r = trip;
      default:            r = 1'b0;
    endcase
    return r;
  endfunction

  // ---- overload thresholds
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ovl
      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          ovl_lvl_ff[gi] <= dsom_pkg::OVL_LVL_RST;
        end else if (WR && ADDR == (dsom_pkg::A_OVL_LVL1 + 3'(gi))) begin
          ovl_lvl_ff[gi] <= WDATA;
        end
      end

      // no run or braking qualifier: the compare is live in every drive state
      dsom_cmp u_ovl_cmp (
        .clk   (CLOCK),
        .rst   (RST),
        .value (OUT_CURRENT),
        .level (ovl_lvl_ff[gi]),
        .flag  (overload_notice[gi])
      );
    end
  endgenerate

  // ---- pid deviation
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dev_lvl_ff <= dsom_pkg::DEV_LVL_RST;
    end else if (WR && ADDR == dsom_pkg::A_DEV_LVL) begin
      dev_lvl_ff <= WDATA;
    end
  end

  always_comb begin
    if (PID_SETPOINT >= PID_FEEDBACK) begin
      dev_mag = PID_SETPOINT - PID_FEEDBACK;
    end else begin
      dev_mag = PID_FEEDBACK - PID_SETPOINT;
    end
  end

  dsom_cmp u_dev_cmp (
    .clk   (CLOCK),
    .rst   (RST),
    .value (dev_mag),
    .level (dev_lvl_ff),
    .flag  (pid_deviation_flag)
  );

  // ---- trip alarm, delayed both ways so a short fault blip is filtered
  dsom_delay #(
    .DELAY (ALARM_DLY_CYC)
  ) u_alarm_dly (
    .clk (CLOCK),
    .rst (RST),
    .d   (TRIP_MODE),
    .q   (trip_alarm)
  );

  // power-up delay before a normally closed relay may pull in
  dsom_delay #(
    .DELAY (POWERUP_CYC)
  ) u_pwr_dly (
    .clk (CLOCK),
    .rst (RST),
    .d   (1'b1),
    .q   (pwr_ok)
  );

  // ---- relay polarity
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pol_nc_ff <= dsom_pkg::POL_NC_RST;
    end else if (WR && ADDR == dsom_pkg::A_POLARITY) begin
      pol_nc_ff <= WDATA[0];
    end
  end

  // ---- outlet routing
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sel
      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          sel_ff[gi] <= dsom_pkg::SEL_RST[gi];
        end else if (WR && ADDR == (dsom_pkg::A_SEL_BASE + 3'(gi))) begin
          sel_ff[gi] <= WDATA;
        end
      end

      always_comb begin
        func_now[gi] = pick(sel_ff[gi], overload_notice, pid_deviation_flag,
                            trip_alarm);
      end
    end
  endgenerate

  // terminals only ever sink: the level is always low, the enable switches
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      term_oe_ff <= 2'h0;
      term_o_ff  <= 2'h0;
    end else begin
      term_oe_ff <= func_now[1:0];
      term_o_ff  <= 2'h0;
    end
  end

  // normally closed: held in once the power-up delay ends, dropped on alarm or lost supply
  always_comb begin
    if (pol_nc_ff) begin
      nxt_coil = pwr_ok && !func_now[2];
    end else begin
      nxt_coil = func_now[2];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      coil_ff <= 1'b0;
    end else begin
      coil_ff <= nxt_coil;
    end
  end

  // ---- register read, data in the cycle after the strobe only
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_ff <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        dsom_pkg::A_OVL_LVL1: rdata_ff <= ovl_lvl_ff[0];
        dsom_pkg::A_OVL_LVL2: rdata_ff <= ovl_lvl_ff[1];
        dsom_pkg::A_DEV_LVL:  rdata_ff <= dev_lvl_ff;
        dsom_pkg::A_POLARITY: rdata_ff <= {7'h00, pol_nc_ff};
        3'h4:                 rdata_ff <= sel_ff[0];
        3'h5:                 rdata_ff <= sel_ff[1];
        3'h6:                 rdata_ff <= sel_ff[2];
        dsom_pkg::A_STATUS: begin
          rdata_ff <= 8'h00;
          rdata_ff[dsom_pkg::ST_OVL1]  <= overload_notice[0];
          rdata_ff[dsom_pkg::ST_OVL2]  <= overload_notice[1];
          rdata_ff[dsom_pkg::ST_DEV]   <= pid_deviation_flag;
          rdata_ff[dsom_pkg::ST_TRIP]  <= trip_alarm;
          rdata_ff[dsom_pkg::ST_COIL]  <= coil_ff;
          rdata_ff[dsom_pkg::ST_PWROK] <= pwr_ok;
        end
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign TERM_OE    = term_oe_ff;
  assign TERM_O     = term_o_ff;
  assign RELAY_COIL = coil_ff;
  assign RDATA      = rdata_ff;

  // ---- checks
  property p_ovl1_set;
    @(posedge CLOCK) disable iff (RST)
      (OUT_CURRENT > ovl_lvl_ff[0]) |=> overload_notice[0];
  endproperty
  a_ovl1_set: assert property (p_ovl1_set) else $error("notice 1 not set");

  property p_ovl1_clr;
    @(posedge CLOCK) disable iff (RST)
      (OUT_CURRENT < ovl_lvl_ff[0]) |=> !overload_notice[0];
  endproperty
  a_ovl1_clr: assert property (p_ovl1_clr) else $error("notice 1 not cleared");

  property p_ovl2;
    @(posedge CLOCK) disable iff (RST)
      (OUT_CURRENT != ovl_lvl_ff[1]) |=>
        (overload_notice[1] == ($past(OUT_CURRENT) > $past(ovl_lvl_ff[1])));
  endproperty
  a_ovl2: assert property (p_ovl2) else $error("notice 2 wrong");

  property p_ovl_rst;
    @(posedge CLOCK) disable iff (RST)
      $past(RST) |-> (ovl_lvl_ff[0] == dsom_pkg::OVL_LVL_RST &&
                      ovl_lvl_ff[1] == dsom_pkg::OVL_LVL_RST);
  endproperty
  a_ovl_rst: assert property (p_ovl_rst) else $error("overload level reset");

  property p_pin;
    @(posedge CLOCK) disable iff (RST)
      1'b1 |=> (TERM_O == 2'h0 && TERM_OE == $past(func_now[1:0]));
  endproperty
  a_pin: assert property (p_pin) else $error("terminal drive wrong");

  property p_dev;
    @(posedge CLOCK) disable iff (RST)
      (dev_mag != dev_lvl_ff) |=>
        (pid_deviation_flag == ($past(dev_mag) > $past(dev_lvl_ff)));
  endproperty
  a_dev: assert property (p_dev) else $error("deviation flag wrong");

  property p_dev_rst;
    @(posedge CLOCK) disable iff (RST)
      $past(RST) |-> (dev_lvl_ff == dsom_pkg::DEV_LVL_RST);
  endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("deviation level reset");

  property p_trip;
    @(posedge CLOCK) disable iff (RST)
      $changed(trip_alarm) |-> (trip_alarm == $past(TRIP_MODE));
  endproperty
  a_trip: assert property (p_trip) else $error("alarm moved against fault");

  property p_route;
    @(posedge CLOCK) disable iff (RST)
      (sel_ff[0] == dsom_pkg::OPT_TRIP) |=> (TERM_OE[0] == $past(trip_alarm));
  endproperty
  a_route: assert property (p_route) else $error("routing wrong");

  sequence s_nc_boot;
    pol_nc_ff && !pwr_ok;
  endsequence

  sequence s_nc_trip;
    pol_nc_ff && pwr_ok && func_now[2];
  endsequence

  property p_nc_boot;
    @(posedge CLOCK) disable iff (RST)
      s_nc_boot |=> !RELAY_COIL;
  endproperty
  a_nc_boot: assert property (p_nc_boot) else $error("coil in before power-up");

  property p_nc_run;
    @(posedge CLOCK) disable iff (RST)
      (pol_nc_ff && pwr_ok) |=> (RELAY_COIL == !$past(func_now[2]));
  endproperty
  a_nc_run: assert property (p_nc_run) else $error("closed relay wrong");

  property p_nc_trip;
    @(posedge CLOCK) disable iff (RST)
      s_nc_trip ##1 (pol_nc_ff && func_now[2]) |-> !RELAY_COIL;
  endproperty
  a_nc_trip: assert property (p_nc_trip) else $error("coil held on trip");

  property p_no;
    @(posedge CLOCK) disable iff (RST)
      !pol_nc_ff |=> (RELAY_COIL == $past(func_now[2]));
  endproperty
  a_no: assert property (p_no) else $error("open relay wrong");

  property p_pol_rst;
    @(posedge CLOCK) disable iff (RST)
      $past(RST) |-> (pol_nc_ff == dsom_pkg::POL_NC_RST && !RELAY_COIL);
  endproperty
  a_pol_rst: assert property (p_pol_rst) else $error("polarity reset");
endmodule

// File: tb/dsom_ext_circuit.sv
// far side of the status outputs: pulled-up terminal wiring and relay contacts
`timescale 1ns/1ps
module dsom_ext_circuit (
  // terminal drive and relay coil from the block
  input  wire logic [1:0] term_o,
  input  wire logic [1:0] term_oe,
  input  wire logic       relay_coil,
  // what the external circuit sees
  output      logic [1:0] term_level,
  output      logic       contact_a_closed,
  output      logic       contact_b_closed
);
  // a released collector floats, so the pull-up sets the level
  assign term_level = (term_oe & term_o) | ~term_oe;
  // energized coil closes common to a, dropped coil closes common to b
  assign contact_a_closed = relay_coil;
  assign contact_b_closed = ~relay_coil;
endmodule

// File: tb/tb.sv
// register tasks and status output tests for the drive status output monitor
`timescale 1ns/1ps
module tb;
  localparam int ADLY = 4;
  localparam int PUP  = 8;
  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       trip  = 1'b0;
  logic [2:0] addr  = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] cur   = 8'h00;
  logic [7:0] sp    = 8'h32;
  logic [7:0] fb    = 8'h32;
  logic [7:0] rdata;
  logic [1:0] term_o;
  logic [1:0] term_oe;
  logic [1:0] term_level;
  logic       coil;
  logic       ca;
  logic       cb;
  logic [7:0] rst_tab [0:6] = '{8'h64, 8'h64, 8'h03, 8'h01, 8'h03, 8'h04, 8'h05};
  int         n_mismatch = 0;
  int         cmp_count  = 0;

  always #50 clk = ~clk;

  dsom_top #(.ALARM_DLY_CYC(ADLY), .POWERUP_CYC(PUP)) dsom_top_i (
    .CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .OUT_CURRENT(cur), .PID_SETPOINT(sp), .PID_FEEDBACK(fb), .TRIP_MODE(trip),
    .TERM_O(term_o), .TERM_OE(term_oe), .RELAY_COIL(coil)
  );

  dsom_ext_circuit dsom_ext_circuit_i (
    .term_o(term_o), .term_oe(term_oe), .relay_coil(coil),
    .term_level(term_level), .contact_a_closed(ca), .contact_b_closed(cb)
  );

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one settle nanosecond so sampling never races the edge updates
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // terminal enable, resolved wire level and the always-low drive value
  task automatic tchk(input logic [1:0] exp_oe);
    chk({6'h0, term_oe}, {6'h0, exp_oe});
    chk({6'h0, term_level}, {6'h0, ~exp_oe});
    chk({6'h0, term_o}, 8'h00);
  endtask

  task automatic coil_chk(input logic exp);
    chk({6'h0, coil, ca}, {6'h0, exp, exp});
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(2);
    coil_chk(1'b0);
    wait_cyc(PUP + 2);
    coil_chk(1'b1);
    chk({7'h0, cb}, 8'h00);
    $display("test power-up relay done");

    for (int i = 0; i < 7; i++) begin
      rd_chk(i[2:0], rst_tab[i]);
    end
    rd_chk(dsom_pkg::A_STATUS, 8'h30);
    $display("test reset values done");

    @(posedge clk) cur <= 8'h65;
    wait_cyc(3);
    tchk(2'b01);
    @(posedge clk) cur <= 8'h64;
    wait_cyc(3);
    tchk(2'b01);
    @(posedge clk) cur <= 8'h63;
    wait_cyc(3);
    tchk(2'b00);
    @(posedge clk) cur <= 8'h64;
    wait_cyc(3);
    tchk(2'b00);
    $display("test overload notice 1 done");

    wr_reg(dsom_pkg::A_OVL_LVL2, 8'h32);
    wr_reg(3'h5, dsom_pkg::OPT_OVL2);
    @(posedge clk) cur <= 8'h33;
    wait_cyc(3);
    tchk(2'b10);
    rd_chk(dsom_pkg::A_STATUS, 8'h32);
    @(posedge clk) cur <= 8'h31;
    wait_cyc(3);
    tchk(2'b00);
    $display("test overload notice 2 done");

    wr_reg(3'h5, dsom_pkg::OPT_DEV);
    @(posedge clk) fb <= 8'h36;
    wait_cyc(3);
    tchk(2'b10);
    @(posedge clk) fb <= 8'h2e;
    wait_cyc(3);
    tchk(2'b10);
    @(posedge clk) fb <= 8'h35;
    wait_cyc(3);
    tchk(2'b10);
    @(posedge clk) fb <= 8'h34;
    wait_cyc(3);
    tchk(2'b00);
    wr_reg(dsom_pkg::A_DEV_LVL, 8'h01);
    wait_cyc(3);
    tchk(2'b10);
    @(posedge clk) fb <= 8'h32;
    wait_cyc(3);
    tchk(2'b00);
    $display("test pid deviation done");

    wr_reg(dsom_pkg::A_SEL_BASE, dsom_pkg::OPT_TRIP);
    @(posedge clk) trip <= 1'b1;
    repeat (2) @(posedge clk);
    trip <= 1'b0;
    wait_cyc(ADLY + 3);
    coil_chk(1'b1);
    tchk(2'b00);
    @(posedge clk) trip <= 1'b1;
    wait_cyc(ADLY - 1);
    coil_chk(1'b1);
    wait_cyc(ADLY);
    coil_chk(1'b0);
    tchk(2'b01);
    rd_chk(dsom_pkg::A_STATUS, 8'h28);
    @(posedge clk) trip <= 1'b0;
    wait_cyc(ADLY + 3);
    coil_chk(1'b1);
    tchk(2'b00);
    $display("test trip alarm closed relay done");

    wr_reg(dsom_pkg::A_POLARITY, 8'h00);
    wait_cyc(2);
    coil_chk(1'b0);
    rd_chk(dsom_pkg::A_POLARITY, 8'h00);
    @(posedge clk) trip <= 1'b1;
    wait_cyc(ADLY + 3);
    coil_chk(1'b1);
    // an unknown option code turns the outlet off even with the trip standing
    wr_reg(dsom_pkg::A_SEL_BASE + 3'h2, 8'h00);
    wait_cyc(2);
    coil_chk(1'b0);
    @(posedge clk) trip <= 1'b0;
    wait_cyc(ADLY + 3);
    coil_chk(1'b0);
    wr_reg(dsom_pkg::A_STATUS, 8'hff);
    rd_chk(dsom_pkg::A_STATUS, 8'h20);
    $display("test open relay done");
    complete_run();
  end

  initial begin
    #300_000;
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
